// ===== shared/sas_map.svh
/*
  register offsets, field positions, reset values and timing counts of the sar converter sequencer.
  assumes a 32-bit axi4-lite register bus with one aligned word per register.
*/
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// byte addresses
`define SAS_ADDR_MODE     8'h00
`define SAS_ADDR_CHAN     8'h04
`define SAS_ADDR_RESULT   8'h08
`define SAS_ADDR_RESULT_H 8'h0c
`define SAS_ADDR_THR_MODE 8'h10
`define SAS_ADDR_THR_VAL  8'h14
`define SAS_ADDR_IRQ_CTRL 8'h18
`define SAS_ADDR_STATUS   8'h1c

// field positions
`define SAS_MODE_RUN_BIT  7
`define SAS_MODE_TSEL_LSB 3
`define SAS_MODE_REF_BIT  0
`define SAS_THR_EN_BIT    7
`define SAS_THR_DIR_BIT   6
`define SAS_IRQ_FLAG_BIT  0

// reset values
`define SAS_RST_MODE     8'h00
`define SAS_RST_CHAN     3'h0
`define SAS_RST_THR_MODE 2'h0
`define SAS_RST_THR_VAL  8'h00

// conversion and sampling lengths in main clock periods, trial count and first trial tap
`define SAS_TCONV_000 9'd288
`define SAS_TCONV_001 9'd240
`define SAS_TCONV_010 9'd192
`define SAS_TCONV_100 9'd144
`define SAS_TCONV_101 9'd120
`define SAS_TCONV_110 9'd96
`define SAS_TSAMP_000 6'd40
`define SAS_TSAMP_001 6'd32
`define SAS_TSAMP_010 6'd24
`define SAS_TSAMP_100 6'd20
`define SAS_TSAMP_101 6'd16
`define SAS_TSAMP_110 6'd12
`define SAS_TRIALS    9'd10
`define SAS_MSB_TRIAL 10'h200

`endif

// ===== shared/sas_pkg.sv
/*
  types shared by the sequencer and its bus slave.
  assumes sas_map.svh holds all numeric constants.
*/
package sas_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_TRIAL  = 2'b11,
    ST_TAIL   = 2'b10
  } sas_state_t;

  typedef struct packed {
    logic oor;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } sas_wr_t;

  typedef struct packed {
    logic ok;
    logic [8:0] total;
    logic [5:0] samp;
    logic [4:0] step;
  } sas_timing_t;

endpackage : sas_pkg

// ===== hdl/sas_axil_slave.sv
/*
  axi4-lite slave front end: takes one write and one read at a time.
  assumes the sequencer answers decode and read data in the cycle of the strobe.
*/
`timescale 1ns/1ps
module sas_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk, // main clock
  input wire logic aresetn, // sync reset, low active
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output sas_pkg::sas_wr_t wr, // held write request
  output logic wr_fire, // write strobe
  input wire logic wr_err, // write hits no register
  output logic rd_oor, // read address has bits set above the low byte
  output logic [7:0] rd_addr, // read address low byte
  output logic rd_fire, // read strobe
  input wire logic [31:0] rd_data, // read word
  input wire logic rd_err // read hits no register
);

  generate
    if (ADDR_W < 8)
    begin : g_bad_addr
      $error("sas_axil_slave: ADDR_W below 8");
    end
  endgenerate

  logic aw_have, w_have;
  logic next_aw_have, next_w_have, next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  sas_pkg::sas_wr_t next_wr;

  assign wr_fire = aw_have && w_have && !bvalid;
  assign rd_fire = arvalid && arready;
  assign rd_addr = araddr[7:0];
  assign rd_oor = (ADDR_W > 8) ? (araddr >> 8) != '0 : 1'b0;

  always_comb
  begin
    next_wr = wr;
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready)
    begin
      next_aw_have = 1'b1;
      next_wr.addr = awaddr[7:0];
      next_wr.oor = (ADDR_W > 8) ? (awaddr >> 8) != '0 : 1'b0;
    end
    if (wvalid && wready)
    begin
      next_w_have = 1'b1;
      next_wr.data = wdata;
      next_wr.strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_err ? 2'h2 : 2'h0;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_err ? 2'h2 : 2'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr <= '0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wr <= next_wr;
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      awready <= !next_aw_have;
      wready <= !next_w_have;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

endmodule : sas_axil_slave

// ===== hdl/sas_adc_seq.sv
/*
  sar converter sequencer: registers, sample/hold timing, ten bit trials, result latch and standby gating.
  assumes an external sample/hold, tap ladder and comparator; comp_in high means input at or above the tap.
*/
// Contract
// - sample for a fixed interval, then hold through all bit trials
// - first trial sets msb at half tap, kept when input at/above it
// - second trial uses 3/4 or 1/4 tap, bit kept when input at/above
// - after ten trials latch result and raise done request together
// - while run stays set, store each result and restart at once
// - clearing run aborts the conversion immediately and stops
// - compare disabled: done request at every conversion end
// - compare enabled, direction zero: request only if upper byte >= threshold
// - compare enabled, direction one: request only if upper byte < threshold
// - result overwritten at every end, whether compare matched or not
// - result read colliding with result write is served first
// - mode/channel write at conversion end wins: no result, no request
// - channel rewrite leaves the done flag alone
// - standby stops the converter
// - after a channel change the next result comes one conversion time later
// - time codes give 288,240,192,144,120,96 periods; 011 and 111 prohibited
// - result sits left-justified in 16 bits; byte view gives upper eight
// - three-bit channel select picks one of eight inputs
// - sampling lasts 40,32,24,20,16,12 periods per legal code
`timescale 1ns/1ps
`include "sas_map.svh"
module sas_adc_seq (
  input wire logic aclk, // main clock, 40 MHz
  input wire logic aresetn, // sync reset, low active
  input wire logic ce, // clock enable, freezes all state
  input wire logic [7:0] awaddr, // axi write address
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi byte enables
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  output logic [1:0] bresp, // axi write response
  output logic bvalid, // axi write response valid
  input wire logic bready, // axi write response ready
  input wire logic [7:0] araddr, // axi read address
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp, // axi read response
  output logic rvalid, // axi read valid
  input wire logic rready, // axi read ready
  input wire logic comp_in, // comparator, async pin
  input wire logic standby_req, // standby request, async pin
  output logic sample_hold, // high while sampling
  output logic [9:0] ladder_tap, // tap code to the ladder
  output logic [2:0] analog_ch_sel, // analog input select
  output logic ref_gen_en, // reference generator enable
  output logic conv_done_irq, // one-cycle done request
  output logic conv_busy // conversion in progress
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus front end

  sas_pkg::sas_wr_t wr;
  logic wr_fire, wr_err, rd_fire, rd_oor, rd_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  sas_axil_slave #(.ADDR_W(8)) u_bus (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr(wr), .wr_fire(wr_fire), .wr_err(wr_err),
    .rd_oor(rd_oor), .rd_addr(rd_addr), .rd_fire(rd_fire),
    .rd_data(rd_data), .rd_err(rd_err)
  );

  function automatic logic mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    mapped = (w <= `SAS_ADDR_STATUS);
  endfunction : mapped

  function automatic sas_pkg::sas_timing_t timing_of(input logic [2:0] code);
    sas_pkg::sas_timing_t t;
    t = '0;
    t.ok = 1'b1;
    case (code)
      3'b000: begin t.total = `SAS_TCONV_000; t.samp = `SAS_TSAMP_000; end
      3'b001: begin t.total = `SAS_TCONV_001; t.samp = `SAS_TSAMP_001; end
      3'b010: begin t.total = `SAS_TCONV_010; t.samp = `SAS_TSAMP_010; end
      3'b100: begin t.total = `SAS_TCONV_100; t.samp = `SAS_TSAMP_100; end
      3'b101: begin t.total = `SAS_TCONV_101; t.samp = `SAS_TSAMP_101; end
      3'b110: begin t.total = `SAS_TCONV_110; t.samp = `SAS_TSAMP_110; end
      default: t.ok = 1'b0;
    endcase
    // remainder of the division lands in the tail, so the total stays exact
    t.step = 5'((t.total - {3'b000, t.samp}) / `SAS_TRIALS);
    return t;
  endfunction : timing_of

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic comp_m, comp_s, stby_m, stby_s;
  logic mode_run, mode_ref, thr_en, thr_dir, flag;
  logic [2:0] mode_tsel, chan_sel;
  logic [7:0] thr_val;
  logic [9:0] result, sar;
  logic [3:0] bit_idx;
  logic [4:0] sub;
  logic [8:0] cnt;
  sas_pkg::sas_state_t state;

  logic next_mode_run, next_mode_ref, next_thr_en, next_thr_dir, next_flag;
  logic [2:0] next_mode_tsel, next_chan_sel;
  logic [7:0] next_thr_val;
  logic [9:0] next_result, next_sar;
  logic [3:0] next_bit_idx;
  logic [4:0] next_sub;
  logic [8:0] next_cnt;
  sas_pkg::sas_state_t next_state;
  logic done_evt, cfg_wr, match, irq_evt;
  sas_pkg::sas_timing_t tim;
  // a sized literal cannot be bit-selected, so the reset words get names first
  localparam logic [7:0] RST_MODE = `SAS_RST_MODE;
  localparam logic [1:0] RST_THR_MODE = `SAS_RST_THR_MODE;

  assign tim = timing_of(mode_tsel);
  assign wr_err = wr.oor || !mapped(wr.addr);
  assign rd_err = rd_oor || !mapped(rd_addr);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux; the word is captured at the handshake edge, before any result update

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_MODE)
      rd_data[7:0] = {mode_run, 1'b0, mode_tsel, 2'b00, mode_ref};
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_CHAN)
      rd_data[2:0] = chan_sel;
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_RESULT)
      rd_data[15:0] = {result, 6'h00};
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_RESULT_H)
      rd_data[7:0] = result[9:2];
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_THR_MODE)
      rd_data[7:6] = {thr_en, thr_dir};
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_THR_VAL)
      rd_data[7:0] = thr_val;
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_IRQ_CTRL)
      rd_data[0] = flag;
    else if ({rd_addr[7:2], 2'b00} == `SAS_ADDR_STATUS)
      rd_data[17:0] = {sar, bit_idx, state, stby_s, conv_busy};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and sequencer

  always_comb
  begin
    next_mode_run = mode_run;
    next_mode_ref = mode_ref;
    next_mode_tsel = mode_tsel;
    next_chan_sel = chan_sel;
    next_thr_en = thr_en;
    next_thr_dir = thr_dir;
    next_thr_val = thr_val;
    next_flag = flag;
    next_result = result;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_sub = sub;
    next_cnt = cnt;
    next_state = state;
    done_evt = 1'b0;
    cfg_wr = 1'b0;
    if (wr_fire && !wr.oor && wr.strb[0])
    begin
      if (wr.addr == `SAS_ADDR_MODE)
      begin
        next_mode_run = wr.data[`SAS_MODE_RUN_BIT];
        next_mode_tsel = wr.data[`SAS_MODE_TSEL_LSB +: 3];
        next_mode_ref = wr.data[`SAS_MODE_REF_BIT];
        cfg_wr = 1'b1;
      end
      else if (wr.addr == `SAS_ADDR_CHAN)
      begin
        next_chan_sel = wr.data[2:0];
        cfg_wr = 1'b1;
      end
      else if (wr.addr == `SAS_ADDR_THR_MODE)
      begin
        next_thr_en = wr.data[`SAS_THR_EN_BIT];
        next_thr_dir = wr.data[`SAS_THR_DIR_BIT];
      end
      else if (wr.addr == `SAS_ADDR_THR_VAL)
        next_thr_val = wr.data[7:0];
      else if (wr.addr == `SAS_ADDR_IRQ_CTRL)
        next_flag = wr.data[`SAS_IRQ_FLAG_BIT];
    end
    case (state)
      sas_pkg::ST_IDLE:
      begin
        if (mode_run && !stby_s && tim.ok)
        begin
          next_state = sas_pkg::ST_SAMPLE;
          next_cnt = 9'd0;
        end
      end
      sas_pkg::ST_SAMPLE:
      begin
        next_cnt = cnt + 9'd1;
        if (cnt == {3'b000, tim.samp} - 9'd1)
        begin
          next_state = sas_pkg::ST_TRIAL;
          next_sar = `SAS_MSB_TRIAL;
          next_bit_idx = 4'd9;
          next_sub = 5'd0;
        end
      end
      sas_pkg::ST_TRIAL:
      begin
        next_cnt = cnt + 9'd1;
        next_sub = sub + 5'd1;
        if (sub == tim.step - 5'd1)
        begin
          next_sub = 5'd0;
          if (!comp_s)
            next_sar[bit_idx] = 1'b0;
          if (bit_idx == 4'd0)
            next_state = sas_pkg::ST_TAIL;
          else
          begin
            next_bit_idx = bit_idx - 4'd1;
            next_sar[bit_idx - 4'd1] = 1'b1;
          end
        end
      end
      sas_pkg::ST_TAIL:
      begin
        next_cnt = cnt + 9'd1;
        if (cnt == tim.total - 9'd1)
        begin
          done_evt = 1'b1;
          next_state = sas_pkg::ST_SAMPLE;
          next_cnt = 9'd0;
          if (!cfg_wr)
            next_result = sar;
        end
      end
      default: next_state = sas_pkg::ST_IDLE;
    endcase
    // a config write while busy restarts the full conversion time
    if (cfg_wr && state != sas_pkg::ST_IDLE)
    begin
      next_state = sas_pkg::ST_SAMPLE;
      next_cnt = 9'd0;
    end
    if (!next_mode_run || stby_s)
      next_state = sas_pkg::ST_IDLE;
    match = !thr_en || (thr_dir ? (sar[9:2] < thr_val) : (sar[9:2] >= thr_val));
    irq_evt = done_evt && !cfg_wr && match;
    if (irq_evt)
      next_flag = 1'b1; // set beats a same-cycle clear
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comp_m <= 1'b0;
      comp_s <= 1'b0;
      stby_m <= 1'b0;
      stby_s <= 1'b0;
      mode_run <= RST_MODE[`SAS_MODE_RUN_BIT];
      mode_ref <= RST_MODE[`SAS_MODE_REF_BIT];
      mode_tsel <= RST_MODE[`SAS_MODE_TSEL_LSB +: 3];
      chan_sel <= `SAS_RST_CHAN;
      thr_en <= RST_THR_MODE[1];
      thr_dir <= RST_THR_MODE[0];
      thr_val <= `SAS_RST_THR_VAL;
      flag <= 1'b0;
      result <= 10'h000;
      sar <= 10'h000;
      bit_idx <= 4'd0;
      sub <= 5'd0;
      cnt <= 9'd0;
      state <= sas_pkg::ST_IDLE;
      sample_hold <= 1'b0;
      ladder_tap <= 10'h000;
      analog_ch_sel <= `SAS_RST_CHAN;
      ref_gen_en <= 1'b0;
      conv_done_irq <= 1'b0;
      conv_busy <= 1'b0;
    end
    else if (ce)
    begin
      comp_m <= comp_in;
      comp_s <= comp_m;
      stby_m <= standby_req;
      stby_s <= stby_m;
      mode_run <= next_mode_run;
      mode_ref <= next_mode_ref;
      mode_tsel <= next_mode_tsel;
      chan_sel <= next_chan_sel;
      thr_en <= next_thr_en;
      thr_dir <= next_thr_dir;
      thr_val <= next_thr_val;
      flag <= next_flag;
      result <= next_result;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      sub <= next_sub;
      cnt <= next_cnt;
      state <= next_state;
      sample_hold <= (next_state == sas_pkg::ST_SAMPLE);
      ladder_tap <= next_sar;
      analog_ch_sel <= next_chan_sel;
      ref_gen_en <= next_mode_ref;
      conv_done_irq <= irq_evt;
      conv_busy <= (next_state != sas_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_hold_in_trials;
    @(posedge aclk) disable iff (!aresetn)
      (state == sas_pkg::ST_TRIAL || state == sas_pkg::ST_TAIL) |-> !sample_hold;
  endproperty
  a_hold_in_trials: assert property (p_hold_in_trials) else $error("sample/hold open during trials");

  property p_msb_first;
    @(posedge aclk) disable iff (!aresetn)
      (ce && state == sas_pkg::ST_SAMPLE && next_state == sas_pkg::ST_TRIAL) |=> (ladder_tap == 10'h200);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial tap is not half scale");

  property p_result_latch;
    @(posedge aclk) disable iff (!aresetn)
      (ce && done_evt && !cfg_wr) |=> (result == $past(sar)) && (conv_done_irq == $past(match));
  endproperty
  a_result_latch: assert property (p_result_latch) else $error("result or request wrong at end");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !next_mode_run && state != sas_pkg::ST_IDLE) |=> (state == sas_pkg::ST_IDLE) && !conv_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("run cleared but converter kept going");

  property p_always_irq;
    @(posedge aclk) disable iff (!aresetn)
      (ce && done_evt && !cfg_wr && !thr_en) |=> conv_done_irq ##1 !conv_done_irq;
  endproperty
  a_always_irq: assert property (p_always_irq) else $error("missing done request with compare off");

  property p_cmp_ge;
    @(posedge aclk) disable iff (!aresetn)
      (ce && done_evt && thr_en && !thr_dir && sar[9:2] < thr_val) |=> !conv_done_irq;
  endproperty
  a_cmp_ge: assert property (p_cmp_ge) else $error("request raised below threshold");

  property p_cmp_lt;
    @(posedge aclk) disable iff (!aresetn)
      (ce && done_evt && thr_en && thr_dir && sar[9:2] >= thr_val) |=> !conv_done_irq;
  endproperty
  a_cmp_lt: assert property (p_cmp_lt) else $error("request raised at or above threshold");

  property p_write_wins;
    @(posedge aclk) disable iff (!aresetn)
      (ce && done_evt && cfg_wr) |=> $stable(result) && !conv_done_irq;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("colliding config write lost to result");

  property p_flag_kept;
    @(posedge aclk) disable iff (!aresetn)
      (ce && flag && wr_fire && wr.addr == `SAS_ADDR_CHAN) |=> flag;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("channel write cleared done flag");

  property p_conv_len;
    @(posedge aclk) disable iff (!aresetn)
      (ce && done_evt) |-> (bit_idx == 4'd0) && (sub == 5'd0) &&
        (cnt >= {3'b000, tim.samp} + 9'd10 * {4'b0000, tim.step});
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion end off its programmed time");

endmodule : sas_adc_seq

// ===== dv/sas_analog_model.sv
/*
  far-side model: sample/hold, tap ladder and comparator of the converter.
  assumes levels holds one 10-bit input code per channel, channel 0 lowest.
*/
`timescale 1ns/1ps
module sas_analog_model (
  input wire logic aclk, // main clock
  input wire logic sample_hold, // high while sampling
  input wire logic [9:0] ladder_tap, // trial tap code
  input wire logic [2:0] analog_ch_sel, // selected input
  input wire logic [79:0] levels, // input codes of all channels
  output logic comp_in // input at or above tap
);
  logic [9:0] held;
  // capacitor keeps the last sample after the switch opens
  always_ff @(posedge aclk)
    if (sample_hold)
      held <= levels[analog_ch_sel*10 +: 10];
  assign comp_in = held >= ladder_tap;
endmodule : sas_analog_model

// ===== dv/tb.sv
/*
  self-checking bench of the converter sequencer over axi4-lite.
  assumes sas_analog_model on the analog side and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [79:0] LV = {10'h37f, 10'h080, 10'h1ff, 10'h200, 10'h2aa, 10'h155, 10'h000, 10'h3ff};
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, standby_req = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, period = 0, cnt = 0, sh = 0, sh_len = 0, irq_n = 0;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, comp_in, sample_hold, ref_gen_en, conv_done_irq, conv_busy;
  logic [9:0] ladder_tap;
  logic [2:0] analog_ch_sel;
  int num_errors = 0, checks = 0;
  sas_adc_seq sas_adc_seq_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .comp_in(comp_in), .standby_req(standby_req),
    .sample_hold(sample_hold), .ladder_tap(ladder_tap), .analog_ch_sel(analog_ch_sel),
    .ref_gen_en(ref_gen_en), .conv_done_irq(conv_done_irq), .conv_busy(conv_busy));
  sas_analog_model sas_analog_model_i (.aclk(aclk), .sample_hold(sample_hold), .ladder_tap(ladder_tap),
    .analog_ch_sel(analog_ch_sel), .levels(LV), .comp_in(comp_in));
  initial forever #12.5 aclk = ~aclk;
  // period between done pulses and length of the last sampling phase
  always @(posedge aclk)
  begin
    if (conv_done_irq)
    begin
      period <= cnt;
      cnt <= 1;
      irq_n <= irq_n + 1;
    end
    else
      cnt <= cnt + 1;
    if (sample_hold)
      sh <= sh + 1;
    else if (sh != 0)
    begin
      sh_len <= sh;
      sh <= 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // write address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end
    while (!bvalid);
    bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : axr
  task automatic run(input logic [2:0] code, input logic [2:0] ch);
    axw(8'h04, {29'h0, ch});
    axw(8'h00, {24'h0, 2'b10, code, 3'b001});
  endtask : run
  task automatic stop();
    axw(8'h00, 32'h01);
    repeat (2) @(posedge aclk);
    chk("busy", {31'h0, conv_busy}, 32'h0);
  endtask : stop
  task automatic conv(input logic [2:0] code, input logic [2:0] ch, input int t, input int s);
    logic [31:0] k;
    k = irq_n;
    run(code, ch);
    repeat (4 * t + 2) @(posedge aclk);
    chk("count", irq_n - k, 32'h4);
    chk("period", period, t);
    chk("sample", sh_len, s);
    chk("chan", {29'h0, analog_ch_sel}, {29'h0, ch});
    axr(8'h08);
    chk("result", d, {16'h0, LV[ch*10 +: 10], 6'h0});
    axr(8'h0c);
    chk("high", d, {24'h0, LV[ch*10+2 +: 8]});
    stop();
  endtask : conv
  task automatic thr(input logic [7:0] m, input logic [7:0] v, input logic [2:0] ch, input logic e);
    logic [31:0] k;
    axw(8'h10, {24'h0, m});
    axw(8'h14, {24'h0, v});
    axw(8'h18, 32'h0);
    k = irq_n;
    run(3'b110, ch);
    repeat (400) @(posedge aclk);
    chk("irq", {31'h0, irq_n != k}, {31'h0, e});
    axr(8'h08);
    chk("overwrite", d, {16'h0, LV[ch*10 +: 10], 6'h0});
    stop();
  endtask : thr
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    axr(8'h00);
    chk("mode", d, 32'h0);
    axr(8'h04);
    chk("chansel", d, 32'h0);
    axr(8'h10);
    chk("thrmode", d, 32'h0);
    axr(8'h14);
    chk("thrval", d, 32'h0);
    axr(8'h20);
    chk("unmapped", {30'h0, r}, 32'h2);
    axw(8'h20, 32'h0);
    chk("wunmapped", {30'h0, bresp}, 32'h2);
    $display("test reset done");
    axw(8'h00, 32'h01);
    repeat (700) @(posedge aclk);
    chk("ref", {31'h0, ref_gen_en}, 32'h1);
    conv(3'b000, 3'd0, 288, 40);
    conv(3'b001, 3'd1, 240, 32);
    conv(3'b010, 3'd2, 192, 24);
    conv(3'b100, 3'd3, 144, 20);
    conv(3'b101, 3'd4, 120, 16);
    conv(3'b110, 3'd7, 96, 12);
    $display("test timing done");
    thr(8'h00, 8'hff, 3'd1, 1);
    thr(8'h80, 8'h80, 3'd4, 1);
    thr(8'h80, 8'h56, 3'd2, 0);
    thr(8'hc0, 8'h80, 3'd0, 0);
    thr(8'hc0, 8'h56, 3'd2, 1);
    axw(8'h04, 32'h5);
    axr(8'h18);
    chk("flag", {31'h0, d[0]}, 32'h1);
    $display("test compare done");
    run(3'b011, 3'd0);
    repeat (20) @(posedge aclk);
    chk("badcode", {31'h0, conv_busy}, 32'h0);
    run(3'b110, 3'd3);
    repeat (30) @(posedge aclk);
    standby_req <= 1;
    repeat (6) @(posedge aclk);
    chk("standby", {31'h0, conv_busy}, 32'h0);
    stop();
    standby_req <= 0;
    $display("test stop done");
    conclude();
  end
  initial
  begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    conclude();
  end
endmodule : tb
